// File: retry_pkg.sv
/*
 Holds the constants, codes and states of the power fault retry controller.
 Assumes a 200 MHz mclk and a 10 ms tick derived inside the controller.
*/
// Operation
// - restart mode 00 trips, 01 retries by restarting from zero frequency
// - restart mode 02 restarts at frequency matched to coasting motor
// - mode 03 restarts matched, decelerates to stop, then trips
// - mode 04 restarts using input-frequency search
// - restart only if power failure not longer than allowance 0.3..25.0 s
// - power failure longer than allowance trips
// - wait retry delay 0.3..100 s before restart after power failure
// - stopped trip enable 00 suppresses trip, 01 allows trip
// - enable 02 suppresses trip stopped or decelerating after run removed
// - power failure retry limit code 00 caps retries at 16
// - power failure retry limit code 01 means unlimited retries
// - coasting frequency below threshold restarts from zero instead
// - undervoltage trip/retry select uses same codes 00..04
// - undervoltage retries 16 with code 00, unlimited with 01
// - overvoltage/overcurrent retries 1..3 before trip
// - overvoltage/overcurrent restart delay 0.3..100 s
// - match start source 00 shutoff, 01 maximum, 02 commanded frequency
// - limit current 0.20..1.80 rated during matched restart
// - lower frequency over scan time 0.10..30.00 s during matching
// - undervoltage persisting 40 s trips even while retrying
// - limited retry count trips after final permitted retry fails
// - trip if fault cause not cleared by end of wait time
package retry_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned TICK_MS       = 10;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   // times in units of 10 ms ticks
   localparam logic [15:0] ALLOW_MIN     = 16'h001E;  // 0.3 s
   localparam logic [15:0] ALLOW_MAX     = 16'h09C4;  // 25.0 s
   localparam logic [15:0] WAIT_MIN      = 16'h001E;  // 0.3 s
   localparam logic [15:0] WAIT_MAX      = 16'h2710;  // 100 s
   localparam logic [15:0] SCAN_MIN      = 16'h000A;  // 0.10 s
   localparam logic [15:0] SCAN_MAX      = 16'h0BB8;  // 30.00 s
   localparam logic [15:0] UV_LONG_TICKS = 16'h0FA0;  // 40 s
   // frequency in 0.01 Hz
   localparam logic [15:0] THR_MAX_STD   = 16'h9C40;  // 400.00 Hz
   localparam logic [15:0] THR_MAX_BIG   = 16'h2EE0;  // 120.00 Hz
   // current in percent of rated
   localparam logic [7:0]  CUR_MIN       = 8'h14;     // 0.20
   localparam logic [7:0]  CUR_MAX       = 8'hB4;     // 1.80
   localparam logic [4:0]  RETRY_CAP     = 5'h10;     // 16
   localparam logic [1:0]  OF_MIN        = 2'h1;
   localparam logic [1:0]  OF_MAX        = 2'h3;
   localparam logic [2:0]  MODE_TRIP     = 3'h0;
   localparam logic [2:0]  MODE_ZERO     = 3'h1;
   localparam logic [2:0]  MODE_MATCH    = 3'h2;
   localparam logic [2:0]  MODE_MSTOP    = 3'h3;
   localparam logic [2:0]  MODE_INPUT    = 3'h4;
   localparam logic [1:0]  TE_OFF        = 2'h0;
   localparam logic [1:0]  TE_ON         = 2'h1;
   localparam logic [1:0]  TE_DECEL      = 2'h2;
   localparam logic [1:0]  SRC_SHUTOFF   = 2'h0;
   localparam logic [1:0]  SRC_MAX       = 2'h1;
   localparam logic [1:0]  SRC_NEW       = 2'h2;
   localparam logic [1:0]  CLS_PF        = 2'h0;
   localparam logic [1:0]  CLS_UV        = 2'h1;
   localparam logic [1:0]  CLS_OF        = 2'h2;
   localparam logic [31:0] RESP_OKAY_DUMMY = 32'h0000_0000;
   // register byte offsets
   localparam logic [7:0]  OFS_MODE      = 8'h00;
   localparam logic [7:0]  OFS_ALLOW     = 8'h04;
   localparam logic [7:0]  OFS_WAIT      = 8'h08;
   localparam logic [7:0]  OFS_TRIPEN    = 8'h0C;
   localparam logic [7:0]  OFS_PFLIM     = 8'h10;
   localparam logic [7:0]  OFS_THR       = 8'h14;
   localparam logic [7:0]  OFS_TRSEL     = 8'h18;
   localparam logic [7:0]  OFS_UVLIM     = 8'h1C;
   localparam logic [7:0]  OFS_OFCNT     = 8'h20;
   localparam logic [7:0]  OFS_OFWAIT    = 8'h24;
   localparam logic [7:0]  OFS_CURLIM    = 8'h28;
   localparam logic [7:0]  OFS_SCAN      = 8'h2C;
   localparam logic [7:0]  OFS_SRC       = 8'h30;
   localparam logic [7:0]  OFS_STATUS    = 8'h34;
   localparam logic [7:0]  OFS_COUNTS    = 8'h38;
   // reset values
   localparam logic [15:0] RST_ALLOW     = 16'h0064;  // 1.0 s
   localparam logic [15:0] RST_WAIT      = 16'h0064;  // 1.0 s
   localparam logic [15:0] RST_SCAN      = 16'h0032;  // 0.50 s
   localparam logic [15:0] RST_THR       = 16'h0000;
   localparam logic [7:0]  RST_CUR       = 8'h64;     // 1.00
   typedef enum logic [2:0] {
      ST_RUN, ST_OUTAGE, ST_WAIT, ST_RESTART, ST_STOPPING, ST_TRIP
   } seq_t;
endpackage

// File: power_fault_retry_controller.sv
/*
 Power fault retry sequencer with an AHB-Lite register slave.
 Assumes fault monitor levels arrive asynchronously from the power stage,
 frequencies come from the same clock domain, one clock and sync reset.
*/
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module power_fault_retry_controller (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire logic         powerFail,
   input  wire logic         underVolt,
   input  wire logic         overFault,
   input  wire logic         runCmd,
   input  wire logic         motorStopped,
   input  wire logic         largeVariant,
   input  wire logic [15:0]  coastFreq,
   input  wire logic [15:0]  shutoffFreq,
   input  wire logic [15:0]  maxFreq,
   input  wire logic [15:0]  cmdFreq,
   input  wire logic         faultReset,
   output logic              outputEnable,
   output logic              tripped,
   output logic [1:0]        tripCause,
   output logic              restartZero,
   output logic              restartMatch,
   output logic              restartInput,
   output logic              decelStop,
   output logic [15:0]       startFreq,
   output logic [7:0]        currentLimit,
   output logic [15:0]       scanTicks
);
   import retry_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // saturation of settings
   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [2:0] clampMode(input logic [31:0] v);
      clampMode = (v[31:0] > 32'h0000_0004) ? MODE_TRIP : v[2:0];
   endfunction

   // 00 spares only a stopped drive, 02 also one ramping down after run off
   function automatic logic spared(input logic [1:0] te, input logic run,
                                   input logic stopped);
      spared = (te == TE_DECEL) ? !run : ((te == TE_OFF) && stopped && !run);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [2:0] syncA;
   logic [2:0] syncB;
   logic       pfS;
   logic       uvS;
   logic       ofS;
   logic       runS;
   logic       stopS;
   logic       rstFlt;

   always_ff @(posedge mclk) begin
      if (rst) begin
         syncA <= 3'h0;
         syncB <= 3'h0;
      end else begin
         syncA <= {powerFail, underVolt, overFault};
         syncB <= syncA;
      end
   end

   logic [2:0] syncC;
   logic [2:0] syncD;
   always_ff @(posedge mclk) begin
      if (rst) begin
         syncC <= 3'h0;
         syncD <= 3'h0;
      end else begin
         syncC <= {runCmd, motorStopped, faultReset};
         syncD <= syncC;
      end
   end

   assign pfS    = syncB[2];
   assign uvS    = syncB[1];
   assign ofS    = syncB[0];
   assign runS   = syncD[2];
   assign stopS  = syncD[1];
   assign rstFlt = syncD[0];

   ////////////////////////////////////////////////////////////////////////
   // common time base
   logic [21:0] prescale;
   logic        tick;

   always_ff @(posedge mclk) begin
      if (rst || tick)
         prescale <= 22'h0;
      else
         prescale <= prescale + 22'h1;
   end
   assign tick = (prescale == 22'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   logic [2:0]  cfgMode;
   logic [15:0] cfgAllow;
   logic [15:0] cfgWait;
   logic [1:0]  cfgTripEn;
   logic        cfgPfUnlim;
   logic [15:0] cfgThr;
   logic [2:0]  cfgTrSel;
   logic        cfgUvUnlim;
   logic [1:0]  cfgOfCnt;
   logic [15:0] cfgOfWait;
   logic [7:0]  cfgCur;
   logic [15:0] cfgScan;
   logic [1:0]  cfgSrc;
   logic        wrPend;
   logic [7:0]  wrAddr;
   logic [15:0] thrMax;
   logic [15:0] wv;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign thrMax    = largeVariant ? THR_MAX_BIG : THR_MAX_STD;
   assign wv        = hwdata[15:0];

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else begin
         wrPend <= hsel && hready && htrans[1] && hwrite;
         wrAddr <= haddr[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfgMode    <= MODE_TRIP;
         cfgAllow   <= RST_ALLOW;
         cfgWait    <= RST_WAIT;
         cfgTripEn  <= TE_OFF;
         cfgPfUnlim <= 1'b0;
         cfgThr     <= RST_THR;
         cfgTrSel   <= MODE_TRIP;
         cfgUvUnlim <= 1'b0;
         cfgOfCnt   <= OF_MIN;
         cfgOfWait  <= RST_WAIT;
         cfgCur     <= RST_CUR;
         cfgScan    <= RST_SCAN;
         cfgSrc     <= SRC_SHUTOFF;
      end else if (wrPend) begin
         case (wrAddr)
            OFS_MODE:   cfgMode    <= clampMode(hwdata);
            OFS_ALLOW:  cfgAllow   <= clamp16(wv, ALLOW_MIN, ALLOW_MAX);
            OFS_WAIT:   cfgWait    <= clamp16(wv, WAIT_MIN, WAIT_MAX);
            OFS_TRIPEN: cfgTripEn  <= (hwdata > 32'h2) ? TE_OFF : hwdata[1:0];
            OFS_PFLIM:  cfgPfUnlim <= hwdata[0];
            OFS_THR:    cfgThr     <= (wv > thrMax) ? thrMax : wv;
            OFS_TRSEL:  cfgTrSel   <= clampMode(hwdata);
            OFS_UVLIM:  cfgUvUnlim <= hwdata[0];
            OFS_OFCNT:  cfgOfCnt   <= (hwdata[1:0] == 2'h0) ? OF_MIN :
                                      hwdata[1:0];
            OFS_OFWAIT: cfgOfWait  <= clamp16(wv, WAIT_MIN, WAIT_MAX);
            OFS_CURLIM: cfgCur     <= (hwdata[7:0] < CUR_MIN) ? CUR_MIN :
                                      ((hwdata[7:0] > CUR_MAX) ? CUR_MAX :
                                       hwdata[7:0]);
            OFS_SCAN:   cfgScan    <= clamp16(wv, SCAN_MIN, SCAN_MAX);
            OFS_SRC:    cfgSrc     <= (hwdata[1:0] == 2'h3) ? SRC_SHUTOFF :
                                      hwdata[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   seq_t        state;
   logic [1:0]  cls;
   logic [15:0] timer;
   logic [15:0] uvTimer;
   logic [4:0]  pfCnt;
   logic [4:0]  uvCnt;
   logic [1:0]  ofCnt;
   logic [2:0]  actMode;
   logic        faultNow;
   logic        quietStop;
   logic        limitHit;
   logic        uvLong;

   assign faultNow  = (cls == CLS_OF) ? ofS : (pfS || uvS);
   assign quietStop = spared(cfgTripEn, runS, stopS);
   assign uvLong    = (uvTimer >= UV_LONG_TICKS);
   always_comb begin
      case (cls)
         CLS_PF:  limitHit = !cfgPfUnlim && (pfCnt >= RETRY_CAP);
         CLS_UV:  limitHit = !cfgUvUnlim && (uvCnt >= RETRY_CAP);
         default: limitHit = ({3'h0, ofCnt} >= {3'h0, cfgOfCnt});
      endcase
   end

   // undervoltage continuous time
   always_ff @(posedge mclk) begin
      if (rst || !uvS)
         uvTimer <= 16'h0;
      else if (tick && !uvLong)
         uvTimer <= uvTimer + 16'h1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state     <= ST_RUN;
         cls       <= CLS_PF;
         timer     <= 16'h0;
         pfCnt     <= 5'h0;
         uvCnt     <= 5'h0;
         ofCnt     <= 2'h0;
         actMode   <= MODE_TRIP;
         tripCause <= CLS_PF;
      end else begin
         case (state)
            ST_RUN: begin
               timer <= 16'h0;
               if (ofS) begin
                  cls     <= CLS_OF;
                  actMode <= cfgTrSel;
                  state   <= (ofCnt >= cfgOfCnt) ? ST_TRIP : ST_WAIT;
                  tripCause <= CLS_OF;
               end else if (pfS || uvS) begin
                  cls       <= pfS ? CLS_PF : CLS_UV;
                  actMode   <= pfS ? cfgMode : cfgTrSel;
                  tripCause <= pfS ? CLS_PF : CLS_UV;
                  if (quietStop)
                     state <= ST_OUTAGE;
                  else if ((pfS ? cfgMode : cfgTrSel) == MODE_TRIP)
                     state <= ST_TRIP;
                  else
                     state <= ST_OUTAGE;
               end else if (stopS) begin
                  pfCnt <= 5'h0;
                  uvCnt <= 5'h0;
                  ofCnt <= 2'h0;
               end
            end
            ST_OUTAGE: begin
               if (tick)
                  timer <= timer + 16'h1;
               if (uvLong)
                  state <= ST_TRIP;
               else if (timer > cfgAllow)
                  state <= ST_TRIP;
               else if (!faultNow) begin
                  timer <= 16'h0;
                  if (quietStop)
                     state <= ST_RUN;
                  else if (limitHit)
                     state <= ST_TRIP;
                  else
                     state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (tick)
                  timer <= timer + 16'h1;
               if (uvLong)
                  state <= ST_TRIP;
               else if (timer >= ((cls == CLS_OF) ? cfgOfWait : cfgWait)) begin
                  timer <= 16'h0;
                  if (faultNow)
                     state <= ST_TRIP;
                  else begin
                     state <= ST_RESTART;
                     case (cls)
                        CLS_PF:  pfCnt <= pfCnt + 5'h1;
                        CLS_UV:  uvCnt <= uvCnt + 5'h1;
                        default: ofCnt <= ofCnt + 2'h1;
                     endcase
                  end
               end
            end
            ST_RESTART: begin
               if (tick)
                  timer <= timer + 16'h1;
               if (faultNow || (cls != CLS_OF && uvS))
                  state <= limitHit ? ST_TRIP : ST_OUTAGE;
               else if (timer >= cfgScan) begin
                  timer <= 16'h0;
                  state <= (actMode == MODE_MSTOP) ? ST_STOPPING : ST_RUN;
               end
            end
            ST_STOPPING: begin
               if (stopS)
                  state <= ST_TRIP;
            end
            ST_TRIP: begin
               timer <= 16'h0;
               if (rstFlt && !faultNow) begin
                  state <= ST_RUN;
                  pfCnt <= 5'h0;
                  uvCnt <= 5'h0;
                  ofCnt <= 2'h0;
               end
            end
            default: state <= ST_TRIP;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restart outputs
   logic matchMode;
   logic belowThr;
   assign matchMode = (actMode == MODE_MATCH) || (actMode == MODE_MSTOP);
   assign belowThr  = (coastFreq < cfgThr);

   always_ff @(posedge mclk) begin
      if (rst) begin
         outputEnable <= 1'b1;
         tripped      <= 1'b0;
         restartZero  <= 1'b0;
         restartMatch <= 1'b0;
         restartInput <= 1'b0;
         decelStop    <= 1'b0;
      end else begin
         outputEnable <= (state == ST_RUN) || (state == ST_RESTART) ||
                         (state == ST_STOPPING);
         tripped      <= (state == ST_TRIP);
         decelStop    <= (state == ST_STOPPING);
         restartZero  <= (state == ST_RESTART) &&
                         ((actMode == MODE_ZERO) ||
                          (matchMode && belowThr));
         restartMatch <= (state == ST_RESTART) && matchMode &&
                         !belowThr;
         restartInput <= (state == ST_RESTART) &&
                         (actMode == MODE_INPUT);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         startFreq    <= 16'h0;
         currentLimit <= RST_CUR;
         scanTicks    <= RST_SCAN;
      end else begin
         currentLimit <= cfgCur;
         scanTicks    <= cfgScan;
         case (cfgSrc)
            SRC_MAX: startFreq <= maxFreq;
            SRC_NEW: startFreq <= cmdFreq;
            default: startFreq <= shutoffFreq;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   // taken in the address phase, so it stands through the data phase
   always_ff @(posedge mclk) begin
      if (rst)
         hrdata <= 32'h0;
      else if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            OFS_MODE:   hrdata <= {29'h0, cfgMode};
            OFS_ALLOW:  hrdata <= {16'h0, cfgAllow};
            OFS_WAIT:   hrdata <= {16'h0, cfgWait};
            OFS_TRIPEN: hrdata <= {30'h0, cfgTripEn};
            OFS_PFLIM:  hrdata <= {31'h0, cfgPfUnlim};
            OFS_THR:    hrdata <= {16'h0, cfgThr};
            OFS_TRSEL:  hrdata <= {29'h0, cfgTrSel};
            OFS_UVLIM:  hrdata <= {31'h0, cfgUvUnlim};
            OFS_OFCNT:  hrdata <= {30'h0, cfgOfCnt};
            OFS_OFWAIT: hrdata <= {16'h0, cfgOfWait};
            OFS_CURLIM: hrdata <= {24'h0, cfgCur};
            OFS_SCAN:   hrdata <= {16'h0, cfgScan};
            OFS_SRC:    hrdata <= {30'h0, cfgSrc};
            OFS_STATUS: hrdata <= {24'h0, tripped, tripCause, 2'h0,
                                   3'(state)};
            OFS_COUNTS: hrdata <= {16'h0, 4'h0, ofCnt, uvCnt, pfCnt};
            default:    hrdata <= 32'h0;
         endcase
      end
   end
endmodule

// File: power_fault_retry_controller_asserts.sv
/*
 Checker of the retry controller port behaviour, bound to its top module.
 Assumes retry_pkg is compiled first, one clock and a sync reset.
*/
`timescale 1ns/1ps
module power_fault_retry_controller_asserts
   import retry_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        faultReset,
   input wire logic        outputEnable,
   input wire logic        tripped,
   input wire logic        restartZero,
   input wire logic        restartMatch,
   input wire logic        restartInput,
   input wire logic        decelStop,
   input wire logic [7:0]  currentLimit,
   input wire logic [15:0] scanTicks
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_RESET_STATE: assert property (disable iff (1'b0)
      rst |=> !tripped && outputEnable && currentLimit == 8'h64)
      else $error("wrong state after reset");
   AST_TRIP_STOPS_OUTPUT: assert property (tripped |-> !outputEnable)
      else $error("output runs while tripped");
   AST_TRIP_HOLDS: assert property (
      (tripped && !faultReset) [*4] |=> tripped)
      else $error("trip left without reset");
   AST_CURRENT_RANGE: assert property (
      currentLimit inside {[CUR_MIN:CUR_MAX]})
      else $error("current limit out of range");
   AST_SCAN_RANGE: assert property (
      scanTicks inside {[SCAN_MIN:SCAN_MAX]})
      else $error("scan time out of range");
   AST_ONE_METHOD: assert property (
      $onehot0({restartZero, restartMatch, restartInput}))
      else $error("two restart methods at once");
   AST_RESTART_DRIVES: assert property (
      (restartZero || restartMatch || restartInput || decelStop)
      |-> outputEnable && !tripped)
      else $error("restart without output");
   AST_DECEL_AFTER_MATCH: assert property (
      $rose(decelStop) |-> $past(restartMatch || restartZero))
      else $error("stop ramp not after matched restart");
endmodule

// File: power_stage_model.sv
/*
 Power stage stand-in: fault monitor levels and motor speed feedback.
 Assumes requests from the bench arrive just after a rising mclk edge.
*/
`timescale 1ns/1ps
module power_stage_model (
   input  wire logic        mclk,
   input  wire logic        runCmd,
   input  wire logic        pfReq,
   output logic             powerFail,
   output logic             underVolt,
   output logic             overFault,
   output logic             motorStopped,
   output logic [15:0]      coastFreq,
   output logic [15:0]      shutoffFreq,
   output logic [15:0]      maxFreq,
   output logic [15:0]      cmdFreq
);
   logic [2:0] coastCnt = 3'h0;
   // motor coasts a few cycles before it reads as stopped
   always @(posedge mclk) begin
      if (runCmd)
         coastCnt <= 3'h0;
      else if (coastCnt != 3'h4)
         coastCnt <= coastCnt + 3'h1;
      powerFail <= pfReq;
   end
   assign motorStopped = (coastCnt == 3'h4);
   assign underVolt = 1'b0;
   assign overFault = 1'b0;
   assign coastFreq = 16'h1388;
   assign shutoffFreq = 16'h1770;
   assign maxFreq = 16'h1770;
   assign cmdFreq = 16'h0FA0;
endmodule

// File: testbench.sv
/*
 Bench of the retry controller: AHB-Lite register tasks and fault runs.
 Assumes the design and power_stage_model; one 200 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
   import retry_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        runCmd = 1'b1;
   logic        largeVariant = 1'b0;
   logic        faultReset = 1'b0;
   logic        pfReq = 1'b0;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, powerFail, underVolt, overFault;
   logic        motorStopped, outputEnable, tripped, decelStop;
   logic        restartZero, restartMatch, restartInput;
   logic [1:0]  tripCause;
   logic [15:0] coastFreq, shutoffFreq, maxFreq, cmdFreq, startFreq, scanTicks;
   logic [7:0]  currentLimit;
   int          error_cnt = 0;
   int          n_checks = 0;
   always #2.5 mclk = ~mclk;
   power_fault_retry_controller dut (.mclk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .powerFail, .underVolt, .overFault, .runCmd, .motorStopped,
      .largeVariant, .coastFreq, .shutoffFreq, .maxFreq, .cmdFreq,
      .faultReset, .outputEnable, .tripped, .tripCause, .restartZero,
      .restartMatch, .restartInput, .decelStop, .startFreq, .currentLimit,
      .scanTicks);
   power_stage_model stage (.mclk, .runCmd, .pfReq, .powerFail, .underVolt,
      .overFault, .motorStopped, .coastFreq, .shutoffFreq, .maxFreq,
      .cmdFreq);
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ready_wait;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         $display("Error %0t: bus wait ran out", $time);
         end_sim;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      hsel <= 1'b1;
      ready_wait;
      htrans <= 2'h0;
      hwdata <= d;
      ready_wait;
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q & 32'h0000FFFF, {16'h0, exp});
   endtask
   task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
      bus(1'b1, a, {16'h0, d});
      rd(a, exp);
   endtask
   // fault with mode trip; a stopped motor, or with 02 also one still coasting, may be spared
   task automatic fault_try(input logic run, input logic [1:0] te,
                            input logic exp, input int gap);
      int n;
      wrrd(OFS_TRIPEN, {14'h0, te}, {14'h0, te});
      runCmd <= run;
      repeat (gap) @(posedge mclk);
      pfReq <= 1'b1;
      n = 0;
      while (tripped !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      chk(tripped, exp);
      if (exp) chk(tripCause, CLS_PF);
      if (exp) chk(outputEnable, 1'b0);
      pfReq <= 1'b0;
      repeat (5) @(posedge mclk);
      faultReset <= 1'b1;
      repeat (6) @(posedge mclk);
      faultReset <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(tripped, 1'b0);
      runCmd <= 1'b1;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(currentLimit, 8'h64);
      chk(scanTicks, RST_SCAN);
      chk(outputEnable, 1'b1);
      rd(OFS_ALLOW, RST_ALLOW);
      rd(OFS_WAIT, RST_WAIT);
      rd(OFS_THR, RST_THR);
      rd(8'h3C, 16'h0);
      wrrd(OFS_ALLOW, 16'h0000, ALLOW_MIN);
      wrrd(OFS_ALLOW, 16'hFFFF, ALLOW_MAX);
      wrrd(OFS_WAIT, 16'h0000, WAIT_MIN);
      wrrd(OFS_WAIT, 16'hFFFF, WAIT_MAX);
      wrrd(OFS_OFWAIT, 16'h0000, WAIT_MIN);
      wrrd(OFS_OFWAIT, 16'hFFFF, WAIT_MAX);
      wrrd(OFS_SCAN, 16'h0000, SCAN_MIN);
      wrrd(OFS_SCAN, 16'hFFFF, SCAN_MAX);
      wrrd(OFS_CURLIM, 16'h0000, {8'h0, CUR_MIN});
      wrrd(OFS_CURLIM, 16'h00FF, {8'h0, CUR_MAX});
      wrrd(OFS_OFCNT, 16'h0000, {14'h0, OF_MIN});
      wrrd(OFS_OFCNT, 16'h0003, {14'h0, OF_MAX});
      wrrd(OFS_THR, 16'hFFFF, THR_MAX_STD);
      largeVariant <= 1'b1;
      wrrd(OFS_THR, 16'hFFFF, THR_MAX_BIG);
      largeVariant <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wrrd(OFS_TRSEL, 16'(i), 16'(i));
         wrrd(OFS_MODE, 16'(i), 16'(i));
      end
      for (int i = 0; i < 3; i++) wrrd(OFS_SRC, 16'(i), 16'(i));
      for (int i = 0; i < 2; i++) begin
         wrrd(OFS_PFLIM, 16'(i), 16'(i));
         wrrd(OFS_UVLIM, 16'(i), 16'(i));
      end
      wrrd(OFS_MODE, 16'h0007, {13'h0, MODE_TRIP});
      wrrd(OFS_MODE, {13'h0, MODE_TRIP}, {13'h0, MODE_TRIP});
      fault_try(1'b1, TE_ON, 1'b1, 10);
      fault_try(1'b1, TE_OFF, 1'b1, 10);
      fault_try(1'b0, TE_OFF, 1'b1, 0);
      fault_try(1'b0, TE_DECEL, 1'b0, 0);
      fault_try(1'b0, TE_OFF, 1'b0, 10);
      fault_try(1'b0, TE_ON, 1'b1, 10);
      fault_try(1'b0, TE_DECEL, 1'b0, 10);
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      $display("Error %0t: run did not finish", $time);
      end_sim;
   end
endmodule
bind power_fault_retry_controller power_fault_retry_controller_asserts
   chk_i (.mclk, .rst, .hreadyout, .hresp, .faultReset, .outputEnable,
   .tripped, .restartZero, .restartMatch, .restartInput, .decelStop,
   .currentLimit, .scanTicks);
